// file: ics_top.sv
/*
 * Self-clearing command registers of a clock translator: the reset-function
 * strobes for the loop internals and the per-event interrupt clear strobes,
 * with a watchdog timer restarted from the same register.
 * Assumes one system clock, an APB master, and interrupt monitor logic
 * outside that applies each clear pulse to its own monitor bits.
 */
// The APB interface to the registers was chosen for this implementation.
// Function
// RL1: every reset-function bit self-clears after a one, acting as one strobe.
// RL2: bit 6 of reset-functions clears the digital loop filter state.
// RL3: bit 5 of reset-functions clears the phase-coherence filter state.
// RL4: bit 3 returns automatic output synchronization logic to reset.
// RL5: bit 2 resets the tuning-word history used for holdover.
// RL6: bit 1 clears all monitor bits, same as all per-event clears.
// RL7: bit 0 restarts the watchdog; after expiry a fresh cycle begins.
// RL8: restart before expiry zeroes the count and raises no timeout.
// RL9: software must restart the watchdog more often than its period.
// RL10: a one in a clear bit resets the matching monitor bit.
// RL11: per-event clear registers self-clear, acting as strobes.
// RL12: clear registers share bit layout with their monitor registers.
// RL13: system and output PLL clear layout, bits 7 and 6 reserved.
// RL14: miscellaneous clear layout, upper three bits reserved.
// RL15: digital PLL clear layout, all eight bits used.
// RL16: limit and history clear layout, upper three bits reserved.
// RL17: input a and b clear layout, bits 7 and 3 reserved.
// RL18: input c and d clear layout, bits 7 and 3 reserved.
// RL19: zero or reserved writes do nothing; strobe bits read zero.
`include "ics_defines.svh"
module ics_top #(
   parameter int ADDR_W = 14,
   parameter int WDT_TICK_CYCLES = `ICS_WDT_TICK_CYCLES
) (
   input wire logic clk_i, // system clock, 250 MHz
   input wire logic resetn_i, // async reset, active low
   input wire logic ce_i, // clock enable, freezes all state
   input wire logic psel_i, // apb select
   input wire logic penable_i, // apb enable
   input wire logic pwrite_i, // apb direction, high for write
   input wire logic [ADDR_W-1:0] paddr_i, // apb byte address
   input wire logic [31:0] pwdata_i, // apb write data
   output logic pready_o, // apb ready
   output logic [31:0] prdata_o, // apb read data
   output logic pslverr_o, // apb error on unmapped index
   output logic loop_filter_clear_o, // pulse: clear loop filter state
   output logic phase_coherence_filter_clear_o, // pulse: clear filter
   output logic auto_sync_reset_o, // pulse: reset auto sync logic
   output logic tuning_word_history_reset_o, // pulse: reset history
   output logic clear_all_events_o, // pulse: every clear below fires
   output logic watchdog_restart_o, // pulse: watchdog restarted
   output logic watchdog_timeout_o, // pulse: watchdog expired
   output logic [7:0] clear_system_pll_events_o, // clear pulses, sys and out pll
   output logic [7:0] clear_misc_events_o, // clear pulses, misc events
   output logic [7:0] clear_loop_state_events_o, // clear pulses, digital pll
   output logic [7:0] clear_limit_history_events_o, // clear pulses, limits
   output logic [7:0] clear_ref_ab_events_o, // clear pulses, inputs a and b
   output logic [7:0] clear_ref_cd_events_o // clear pulses, inputs c and d
);
   localparam int NCLR = 6;

   // implemented bits of each clear register, in index order
   localparam logic [7:0] CLR_MASK [NCLR] = '{
      `ICS_CLR_SYS_MASK, // [RL13]
      `ICS_CLR_MISC_MASK, // [RL14]
      `ICS_CLR_LOOP_MASK, // [RL15]
      `ICS_CLR_LIMIT_MASK, // [RL16]
      `ICS_CLR_REF_MASK, // [RL17]
      `ICS_CLR_REF_MASK // [RL18]
   };

   ics_bus_if bus ();
   ics_wdt_if wd ();

   // refuse sizes the logic cannot serve
   generate
      if (ADDR_W < 14) begin : g_bad_addr
         $error("ics_top: ADDR_W must be at least 14");
      end
      if (WDT_TICK_CYCLES < 1) begin : g_bad_tick
         $error("ics_top: WDT_TICK_CYCLES must be at least 1");
      end
   endgenerate

   // apb protocol handling
   ics_apb_slave #(
      .ADDR_W(ADDR_W)
   ) u_apb (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .psel_i(psel_i),
      .penable_i(penable_i),
      .pwrite_i(pwrite_i),
      .paddr_i(paddr_i),
      .pwdata_i(pwdata_i),
      .pready_o(pready_o),
      .prdata_o(prdata_o),
      .pslverr_o(pslverr_o),
      .bus(bus.slave)
   );

   // watchdog timer, restarted by the reset-function strobe
   ics_watchdog #(
      .TICK_CYCLES(WDT_TICK_CYCLES)
   ) u_wdt (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .ce_i(ce_i),
      .wd(wd.timer)
   );

   logic [7:0] rst_fn_reg;
   logic [7:0] clr_reg [NCLR];
   ics_pkg::ics_wdt_cnt_t wdt_period_reg;
   logic [7:0] wdt_tocnt_reg;
   logic wr_rst_fn;
   logic wr_wdt_period;
   logic wr_wdt_status;
   logic [7:0] rst_fn_next;
   logic clear_all_next;

   // write decode by register index
   assign wr_rst_fn = bus.wr && (bus.idx == `ICS_IDX_RESET_FN);
   assign wr_wdt_period = bus.wr && (bus.idx == `ICS_IDX_WDT_PERIOD);
   assign wr_wdt_status = bus.wr && (bus.idx == `ICS_IDX_WDT_STATUS);

   // reserved bits and zeros written give no strobe
   assign rst_fn_next = wr_rst_fn ? (bus.wdata[7:0] & `ICS_RST_FN_MASK) : 8'h00; // [RL19]
   assign clear_all_next = rst_fn_next[`ICS_RST_CLEAR_ALL_BIT];

   // reset-function strobes: held one cycle, then back to zero
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_fn_reg <= 8'h00;
      end else if (ce_i) begin
         rst_fn_reg <= rst_fn_next; // [RL1]
      end
   end

   // strobe fan-out to the loop internals
   assign loop_filter_clear_o = rst_fn_reg[`ICS_RST_LOOP_FILTER_BIT]; // [RL2]
   assign phase_coherence_filter_clear_o = rst_fn_reg[`ICS_RST_PHASE_COH_BIT]; // [RL3]
   assign auto_sync_reset_o = rst_fn_reg[`ICS_RST_AUTO_SYNC_BIT]; // [RL4]
   assign tuning_word_history_reset_o = rst_fn_reg[`ICS_RST_TW_HISTORY_BIT]; // [RL5]
   assign clear_all_events_o = rst_fn_reg[`ICS_RST_CLEAR_ALL_BIT]; // [RL6]
   assign watchdog_restart_o = rst_fn_reg[`ICS_RST_WATCHDOG_BIT];

   // restart goes in the same cycle the strobe leaves the register,
   // so the count returns to zero at the edge that ends the visible pulse
   assign wd.restart = rst_fn_reg[`ICS_RST_WATCHDOG_BIT]; // [RL7]
   assign wd.period = wdt_period_reg;
   assign watchdog_timeout_o = wd.timeout;

   // per-event clear registers, one per monitor register
   generate
      for (genvar i = 0; i < NCLR; i++) begin : g_clr
         logic hit_i;
         logic [7:0] next_i;
         assign hit_i = bus.wr && (bus.idx == 12'(`ICS_IDX_CLR_SYS + i));
         // clear-all sets every implemented bit, same as a full write
         assign next_i = ((hit_i ? bus.wdata[7:0] : 8'h00)
                          | (clear_all_next ? 8'hFF : 8'h00)) & CLR_MASK[i]; // [RL6] [RL19]
         always_ff @(posedge clk_i or negedge resetn_i) begin
            if (!resetn_i) begin
               clr_reg[i] <= 8'h00;
            end else if (ce_i) begin
               clr_reg[i] <= next_i; // [RL10] [RL11]
            end
         end
      end
   endgenerate

   // bit positions pass straight through so the monitor side can
   // apply each one to the bit of the same position
   assign clear_system_pll_events_o = clr_reg[0]; // [RL12]
   assign clear_misc_events_o = clr_reg[1];
   assign clear_loop_state_events_o = clr_reg[2];
   assign clear_limit_history_events_o = clr_reg[3];
   assign clear_ref_ab_events_o = clr_reg[4];
   assign clear_ref_cd_events_o = clr_reg[5];

   // watchdog period in 1 ms units; zero keeps the timer stopped
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wdt_period_reg <= `ICS_WDT_PERIOD_RST;
      end else if (ce_i && wr_wdt_period) begin
         wdt_period_reg <= bus.wdata[15:0];
      end
   end

   // saturating count of expiries; a write to the status register clears it, but an expiry
   // in the same cycle is kept so no event is lost
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         wdt_tocnt_reg <= 8'h00;
      end else if (ce_i) begin
         if (wd.timeout) begin
            if (wr_wdt_status) wdt_tocnt_reg <= 8'h01;
            else if (wdt_tocnt_reg != 8'hFF) wdt_tocnt_reg <= wdt_tocnt_reg + 8'h01;
         end else if (wr_wdt_status) begin
            wdt_tocnt_reg <= 8'h00;
         end
      end
   end

   // read mux: command registers are write-only and read as zero
   always_comb begin
      bus.rdata = 32'h0000_0000;
      bus.hit = 1'b1;
      unique case (bus.idx)
         `ICS_IDX_RESET_FN, `ICS_IDX_CLR_SYS, `ICS_IDX_CLR_MISC, `ICS_IDX_CLR_LOOP,
         `ICS_IDX_CLR_LIMIT, `ICS_IDX_CLR_REF_AB, `ICS_IDX_CLR_REF_CD: begin
            bus.rdata = 32'h0000_0000; // [RL19]
         end
         `ICS_IDX_WDT_PERIOD: begin
            bus.rdata = {16'h0000, wdt_period_reg};
         end
         `ICS_IDX_WDT_STATUS: begin
            bus.rdata[`ICS_STAT_COUNT_LSB +: 16] = wd.count;
            bus.rdata[`ICS_STAT_RUNNING_BIT] = wd.running;
            bus.rdata[`ICS_STAT_TOCNT_LSB +: 8] = wdt_tocnt_reg;
         end
         default: begin
            bus.hit = 1'b0;
         end
      endcase
   end
endmodule

// file: ics_defines.svh
/*
 * Register indices, bit positions, field masks, reset values and timing
 * figures of the strobe and event-clear block.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef ICS_DEFINES_SVH
`define ICS_DEFINES_SVH

// register indices; byte address is four times the index
`define ICS_IDX_RESET_FN 12'hA03
`define ICS_IDX_CLR_SYS 12'hA04
`define ICS_IDX_CLR_MISC 12'hA05
`define ICS_IDX_CLR_LOOP 12'hA06
`define ICS_IDX_CLR_LIMIT 12'hA07
`define ICS_IDX_CLR_REF_AB 12'hA08
`define ICS_IDX_CLR_REF_CD 12'hA09
`define ICS_IDX_WDT_PERIOD 12'hA10
`define ICS_IDX_WDT_STATUS 12'hA11

// reset-function strobe bit positions
`define ICS_RST_LOOP_FILTER_BIT 6
`define ICS_RST_PHASE_COH_BIT 5
`define ICS_RST_AUTO_SYNC_BIT 3
`define ICS_RST_TW_HISTORY_BIT 2
`define ICS_RST_CLEAR_ALL_BIT 1
`define ICS_RST_WATCHDOG_BIT 0

// implemented bits of each command register
`define ICS_RST_FN_MASK 8'h6F
`define ICS_CLR_SYS_MASK 8'h3F
`define ICS_CLR_MISC_MASK 8'h1F
`define ICS_CLR_LOOP_MASK 8'hFF
`define ICS_CLR_LIMIT_MASK 8'h1F
`define ICS_CLR_REF_MASK 8'h77

// watchdog period field and status layout
`define ICS_WDT_PERIOD_RST 16'h0000
`define ICS_STAT_COUNT_LSB 0
`define ICS_STAT_RUNNING_BIT 16
`define ICS_STAT_TOCNT_LSB 24

// timing: one watchdog period unit, in ns, and the clock period
`define ICS_WDT_TICK_NS 1000000
`define ICS_CLK_PERIOD_NS 4
`define ICS_WDT_TICK_CYCLES (`ICS_WDT_TICK_NS / `ICS_CLK_PERIOD_NS)

`endif

// file: ics_pkg.sv
/*
 * Types shared by the strobe and event-clear block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package ics_pkg;
   typedef logic [31:0] ics_word_t;
   typedef logic [11:0] ics_idx_t;
   typedef logic [7:0] ics_byte_t;
   typedef logic [15:0] ics_wdt_cnt_t;
   // one-hot watchdog states
   typedef enum logic [1:0] {
      ICS_WD_IDLE = 2'b01,
      ICS_WD_RUN = 2'b10
   } ics_wd_state_e;
endpackage

// file: ics_if.sv
/*
 * Carriers between the block's own modules: the decoded register access
 * and the watchdog control path.
 * Assumes the package is compiled first.
 */
interface ics_bus_if;
   logic wr;
   logic rd;
   ics_pkg::ics_idx_t idx;
   ics_pkg::ics_word_t wdata;
   ics_pkg::ics_word_t rdata;
   logic hit;
   modport slave (output wr, rd, idx, wdata, input rdata, hit);
   modport core (input wr, rd, idx, wdata, output rdata, hit);
endinterface

interface ics_wdt_if;
   logic restart;
   ics_pkg::ics_wdt_cnt_t period;
   ics_pkg::ics_wdt_cnt_t count;
   logic running;
   logic timeout;
   modport ctl (output restart, period, input count, running, timeout);
   modport timer (input restart, period, output count, running, timeout);
endinterface

// file: ics_apb_slave.sv
/*
 * APB slave front end: zero-wait access, read data and error taken into
 * flops during the setup cycle so they stand through the access phase.
 * Assumes one clock domain; ce_i low stalls by holding pready low.
 */
module ics_apb_slave #(
   parameter int ADDR_W = 14
) (
   input wire logic clk_i, // system clock
   input wire logic resetn_i, // async reset, active low
   input wire logic ce_i, // clock enable
   input wire logic psel_i, // apb select
   input wire logic penable_i, // apb enable
   input wire logic pwrite_i, // apb direction
   input wire logic [ADDR_W-1:0] paddr_i, // apb byte address
   input wire logic [31:0] pwdata_i, // apb write data
   output logic pready_o, // apb ready
   output logic [31:0] prdata_o, // apb read data
   output logic pslverr_o, // apb error
   ics_bus_if.slave bus // decoded access
);
   logic [31:0] prdata_reg;
   logic pslverr_reg;

   // writes act only at the access edge; frozen cycles never complete
   assign bus.wr = psel_i & penable_i & pwrite_i & ce_i;
   assign bus.rd = psel_i & ~penable_i;
   assign bus.idx = paddr_i[13:2];
   assign bus.wdata = pwdata_i;
   assign pready_o = ce_i;
   assign prdata_o = prdata_reg;
   assign pslverr_o = pslverr_reg;

   // capture answer in setup so it is a flop output during access
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (ce_i && bus.rd) begin
         prdata_reg <= pwrite_i ? 32'h0000_0000 : bus.rdata;
         pslverr_reg <= ~bus.hit;
      end
   end
endmodule

// file: ics_watchdog.sv
/*
 * Watchdog timer: counts period units, pulses on expiry and restarts.
 * Assumes the period arrives from a register and the restart strobe is
 * a one-cycle pulse; a period of zero stops the timer.
 */
`include "ics_defines.svh"
module ics_watchdog #(
   parameter int TICK_CYCLES = `ICS_WDT_TICK_CYCLES
) (
   input wire logic clk_i, // system clock
   input wire logic resetn_i, // async reset, active low
   input wire logic ce_i, // clock enable
   ics_wdt_if.timer wd // control and state
);
   ics_pkg::ics_wd_state_e state_reg;
   logic [31:0] pre_reg;
   ics_pkg::ics_wdt_cnt_t count_reg;
   logic timeout_reg;
   logic tick;

   assign tick = (pre_reg == 32'(TICK_CYCLES - 1));
   assign wd.count = count_reg;
   assign wd.running = (state_reg == ics_pkg::ICS_WD_RUN);
   assign wd.timeout = timeout_reg;

   // state follows the period register
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) state_reg <= ics_pkg::ICS_WD_IDLE;
      else if (ce_i) begin
         unique case (state_reg)
            ics_pkg::ICS_WD_IDLE: if (wd.period != 16'h0000) state_reg <= ics_pkg::ICS_WD_RUN;
            ics_pkg::ICS_WD_RUN: if (wd.period == 16'h0000) state_reg <= ics_pkg::ICS_WD_IDLE;
         endcase
      end
   end

   // restart beats expiry in the same cycle: no timeout is raised
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pre_reg <= 32'h0000_0000;
         count_reg <= 16'h0000;
         timeout_reg <= 1'b0;
      end else if (ce_i) begin
         timeout_reg <= 1'b0;
         if (wd.restart || state_reg != ics_pkg::ICS_WD_RUN) begin // [RL7] [RL8]
            pre_reg <= 32'h0000_0000;
            count_reg <= 16'h0000;
         end else if (tick) begin
            pre_reg <= 32'h0000_0000;
            if (count_reg + 16'h0001 >= wd.period) begin
               count_reg <= 16'h0000; // expired: new timing cycle
               timeout_reg <= 1'b1;
            end else begin
               count_reg <= count_reg + 16'h0001;
            end
         end else begin
            pre_reg <= pre_reg + 32'h0000_0001;
         end
      end
   end
endmodule

// file: ics_chk.sv
/* Concurrent checks on the ports of ics_top.
   Assumes one clock domain; bound to ics_top by the statement at the foot. */
`include "ics_defines.svh"
module ics_chk #(
   parameter int ADDR_W = 14,
   parameter int WDT_TICK_CYCLES = 4
) (
   input wire logic clk_i, // clock
   input wire logic resetn_i, // reset, active low
   input wire logic ce_i, // clock enable
   input wire logic psel_i, // apb select
   input wire logic penable_i, // apb enable
   input wire logic pwrite_i, // apb direction
   input wire logic [ADDR_W-1:0] paddr_i, // apb address
   input wire logic [31:0] pwdata_i, // apb write data
   input wire logic pready_o, // apb ready
   input wire logic [31:0] prdata_o, // apb read data
   input wire logic pslverr_o, // apb error
   input wire logic loop_filter_clear_o, // strobe
   input wire logic phase_coherence_filter_clear_o, // strobe
   input wire logic auto_sync_reset_o, // strobe
   input wire logic tuning_word_history_reset_o, // strobe
   input wire logic clear_all_events_o, // strobe
   input wire logic watchdog_restart_o, // strobe
   input wire logic watchdog_timeout_o, // expiry pulse
   input wire logic [7:0] clear_system_pll_events_o, // clears
   input wire logic [7:0] clear_misc_events_o, // clears
   input wire logic [7:0] clear_loop_state_events_o, // clears
   input wire logic [7:0] clear_limit_history_events_o, // clears
   input wire logic [7:0] clear_ref_ab_events_o, // clears
   input wire logic [7:0] clear_ref_cd_events_o // clears
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   logic [ADDR_W-3:0] idx;
   logic wr, fn_wr, any_fn;
   // decoded write as the slave takes it; ce low stalls, so it counts
   assign idx = paddr_i[ADDR_W-1:2];
   assign wr = psel_i && penable_i && pwrite_i && ce_i;
   assign fn_wr = wr && idx == `ICS_IDX_RESET_FN;
   assign any_fn = loop_filter_clear_o | phase_coherence_filter_clear_o | auto_sync_reset_o |
      tuning_word_history_reset_o | clear_all_events_o | watchdog_restart_o;
   a_loop_filter_pulse: assert property (fn_wr && pwdata_i[6] |=> loop_filter_clear_o)
      else $error("loop filter clear missing");
   a_phase_coh_pulse: assert property (fn_wr && pwdata_i[5] |=> phase_coherence_filter_clear_o)
      else $error("phase filter clear missing");
   a_auto_sync_pulse: assert property (fn_wr && pwdata_i[3] |=> auto_sync_reset_o)
      else $error("auto sync reset missing");
   a_history_pulse: assert property (fn_wr && pwdata_i[2] |=> tuning_word_history_reset_o)
      else $error("history reset missing");
   a_wdt_restart_pulse: assert property (fn_wr && pwdata_i[0] |=> watchdog_restart_o)
      else $error("watchdog restart missing");
   a_fn_self_clear: assert property (fn_wr ##1 (ce_i && !fn_wr) |=> !any_fn)
      else $error("strobe did not self clear");
   a_no_stray_pulse: assert property ($rose(loop_filter_clear_o) |-> $past(fn_wr && pwdata_i[6]))
      else $error("loop filter clear without cause");
   a_clear_all_fans: assert property (clear_all_events_o |-> clear_system_pll_events_o == 8'h3F &&
      clear_misc_events_o == 8'h1F && clear_loop_state_events_o == 8'hFF &&
      clear_limit_history_events_o == 8'h1F && clear_ref_ab_events_o == 8'h77 &&
      clear_ref_cd_events_o == 8'h77) else $error("clear all did not fan out");
   a_loop_clear_pulse: assert property (wr && idx == 12'hA06 |=>
      clear_loop_state_events_o == $past(pwdata_i[7:0])) else $error("loop clear mismatch");
   a_ref_ab_pulse: assert property (wr && idx == 12'hA08 |=>
      clear_ref_ab_events_o == ($past(pwdata_i[7:0]) & 8'h77)) else $error("ref ab clear mismatch");
   a_clear_self_clear: assert property (wr && idx == 12'hA06 ##1 (ce_i && !wr) |=>
      clear_loop_state_events_o == 8'h00) else $error("loop clear did not self clear");
   a_reserved_quiet: assert property ((clear_system_pll_events_o & 8'hC0) == 8'h00 &&
      (clear_misc_events_o & 8'hE0) == 8'h00 && (clear_limit_history_events_o & 8'hE0) == 8'h00 &&
      (clear_ref_cd_events_o & 8'h88) == 8'h00) else $error("reserved clear bit pulsed");
   a_unmapped_err: assert property (psel_i && !penable_i && ce_i && (idx < 12'hA03 || idx > 12'hA11)
      |=> pslverr_o) else $error("unmapped access not refused");
   // main scenarios reached
   c_clear_all: cover property (fn_wr && pwdata_i[1]);
   c_timeout: cover property (watchdog_timeout_o);
   c_stall: cover property (psel_i && penable_i && !pready_o);
endmodule

bind ics_top ics_chk #(.ADDR_W(ADDR_W), .WDT_TICK_CYCLES(WDT_TICK_CYCLES)) u_ics_chk (
   .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
   .prdata_o(prdata_o), .pslverr_o(pslverr_o), .loop_filter_clear_o(loop_filter_clear_o),
   .phase_coherence_filter_clear_o(phase_coherence_filter_clear_o),
   .auto_sync_reset_o(auto_sync_reset_o), .clear_all_events_o(clear_all_events_o),
   .tuning_word_history_reset_o(tuning_word_history_reset_o),
   .watchdog_restart_o(watchdog_restart_o), .watchdog_timeout_o(watchdog_timeout_o),
   .clear_system_pll_events_o(clear_system_pll_events_o), .clear_misc_events_o(clear_misc_events_o),
   .clear_loop_state_events_o(clear_loop_state_events_o),
   .clear_limit_history_events_o(clear_limit_history_events_o),
   .clear_ref_ab_events_o(clear_ref_ab_events_o), .clear_ref_cd_events_o(clear_ref_cd_events_o));

// file: ics_tb_top.sv
/* Self-checking bench for ics_top: strobe and clear writes, stall, watchdog.
   Assumes design files and the checker are compiled before it. */
`include "ics_defines.svh"
module ics_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TICK = 4;
   logic clk_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1;
   logic psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
   logic [13:0] paddr_i = 14'h0000;
   logic [31:0] pwdata_i = 32'h00000000, prdata_o, rd;
   logic pready_o, pslverr_o, err, lf, pc, sy, th, ca, wr, wt;
   logic [7:0] c_sys, c_misc, c_loop, c_lim, c_ab, c_cd;
   int n_fail = 0, comparisons = 0, cyc = 0, n_to = 0;
   wire [55:0] outs = {1'b0, lf, pc, 1'b0, sy, th, ca, wr, c_sys, c_misc, c_loop, c_lim, c_ab, c_cd};
   ics_top #(.WDT_TICK_CYCLES(TICK)) u_ics_top (
      .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(ce_i), .psel_i(psel_i), .penable_i(penable_i),
      .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
      .prdata_o(prdata_o), .pslverr_o(pslverr_o), .loop_filter_clear_o(lf),
      .phase_coherence_filter_clear_o(pc), .auto_sync_reset_o(sy),
      .tuning_word_history_reset_o(th), .clear_all_events_o(ca), .watchdog_restart_o(wr),
      .watchdog_timeout_o(wt), .clear_system_pll_events_o(c_sys), .clear_misc_events_o(c_misc),
      .clear_loop_state_events_o(c_loop), .clear_limit_history_events_o(c_lim),
      .clear_ref_ab_events_o(c_ab), .clear_ref_cd_events_o(c_cd));
   // 250 MHz clock
   always #2 clk_i = ~clk_i;
   // cycle tally and hang guard; the run needs about 500 cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         final_report();
      end
   end
   // expiry pulses counted mid-cycle, where the output has settled
   always @(negedge clk_i) if (wt === 1'b1) n_to++;
   task automatic final_report();
      $display("mismatches %0d comparisons %0d", n_fail, comparisons);
      if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // one apb transfer; returns at the edge where pready was sampled high
   task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] d);
      int n;
      // a release still pending in this step: let one edge pass first
      if (psel_i === 1'b1) @(posedge clk_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= {idx, 2'b00};
      pwdata_i <= d;
      @(posedge clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 50);
      if (n >= 50) n_fail++;
      rd = prdata_o;
      err = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask
   // expected pulses: strobes then six clear groups; clear-all sets every mask
   function automatic logic [55:0] expect_outs(input logic [11:0] idx, input logic [7:0] d);
      logic [47:0] m, r;
      m = 48'h3F1FFF1F7777;
      r = 48'h0;
      for (int i = 0; i < 6; i++) if (idx == 12'hA04 + i) r[47-8*i -: 8] = d & m[47-8*i -: 8];
      if (idx == `ICS_IDX_RESET_FN && d[1]) r = m;
      return {(idx == `ICS_IDX_RESET_FN) ? d & 8'h6F : 8'h00, r};
   endfunction
   // write, see the one-cycle pulses, then see them gone
   task automatic check_write(input logic [11:0] idx, input logic [31:0] d);
      apb(1'b1, idx, d);
      #1;
      chk(outs, expect_outs(idx, d[7:0]));
      @(posedge clk_i);
      #1;
      chk(outs, 56'h0);
      @(posedge clk_i);
   endtask
   initial begin
      logic [11:0] idx;
      int n;
      int t;
      void'($urandom(32'h5f5d6049));
      repeat (5) @(posedge clk_i);
      resetn_i <= 1'b1;
      @(posedge clk_i);
      #1;
      chk(outs, 56'h0);
      @(posedge clk_i);
      // every bit of every command register alone, a zero write, and a read back
      for (int r = 0; r < 7; r++) begin
         for (int b = 0; b < 8; b++) check_write(12'(12'hA03 + r), 32'h1 << b);
         check_write(12'(12'hA03 + r), 32'h0);
         apb(1'b0, 12'(12'hA03 + r), 32'h0);
         chk({err, rd}, 33'h0);
      end
      repeat (40) begin
         idx = 12'hA03 + 12'($urandom_range(6, 0));
         check_write(idx, $urandom);
      end
      // unmapped index: refused, no pulses
      apb(1'b0, 12'h000, 32'h0);
      chk({err, rd}, {1'b1, 32'h0});
      check_write(12'hA0A, 32'hFF);
      // stall with ce low, write lands once ce returns
      ce_i <= 1'b0;
      fork
         check_write(12'hA06, 32'hA5);
         begin
            repeat (3) @(posedge clk_i);
            ce_i <= 1'b1;
         end
      join
      // watchdog: period 2 units, restart, two expiries in a row
      apb(1'b1, 12'hA10, 32'h2);
      apb(1'b1, `ICS_IDX_RESET_FN, 32'h1);
      #1;
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(posedge clk_i);
            #1;
            n++;
         end while (wt !== 1'b1 && n < 50);
         // first wait also spans the cycle the strobe needs to leave its register
         chk(n, 2 * TICK + ((k == 0) ? 1 : 0));
      end
      @(posedge clk_i);
      // restarts every three cycles keep the timer from expiring
      t = n_to;
      repeat (6) begin
         apb(1'b1, `ICS_IDX_RESET_FN, 32'h1);
         @(posedge clk_i);
      end
      chk(n_to, t);
      apb(1'b1, 12'hA10, 32'h0);
      final_report();
   end
endmodule
